// [rtl/sync_serial_rx_tx.v]
// synchronous serial receiver and transmitter, character oriented
`include "sync_serial_consts.vh"
`default_nettype none
module sync_serial_rx_tx (
  input  wire       mclk_i,
  input  wire       rstn_i,
  input  wire       ce_i,
  input  wire [7:0] parallel_in_bus_i,
  input  wire       tx_sync_load_strobe_i,
  input  wire       tx_data_load_strobe_i,
  input  wire       rx_sync_load_strobe_i,
  input  wire       control_load_strobe_i,
  input  wire       length_sel_hi_i,
  input  wire       length_sel_lo_i,
  input  wire       parity_disable_i,
  input  wire       parity_sense_i,
  input  wire       tx_bit_clock_i,
  input  wire       rx_bit_clock_i,
  input  wire       serial_in_i,
  input  wire       receiver_clear_i,
  input  wire       rx_ready_clear_i,
  input  wire       rx_out_enable_i,
  output wire [7:0] rx_char_out_o,
  output wire [7:0] rx_char_out_oe_o,
  output wire       rx_char_ready_o,
  output wire       rx_overrun_flag_o,
  output wire       rx_parity_fault_o,
  output wire       rx_sync_match_o,
  output wire       serial_out_o,
  output wire       tx_buffer_free_o,
  output wire       tx_sync_sent_o
);
  localparam W = `SSRT_CHAR_W;
  localparam CW = `SSRT_CNT_W;
  // reset release
  reg rst_m_q;
  reg rst_n;
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_m_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n   <= rst_m_q;
    end
  end
  // pin synchronisers, one per asynchronous input
  localparam NS = 20;
  wire [NS-1:0] s_in;
  wire [NS-1:0] s_lvl;
  wire [NS-1:0] s_rise;
  wire [NS-1:0] s_fall;
  assign s_in = {parallel_in_bus_i, tx_sync_load_strobe_i, tx_data_load_strobe_i,
                 rx_sync_load_strobe_i, control_load_strobe_i, length_sel_hi_i,
                 length_sel_lo_i, parity_disable_i, parity_sense_i, tx_bit_clock_i,
                 rx_bit_clock_i, serial_in_i, receiver_clear_i};
  genvar g;
  generate
    for (g = 0; g < NS - 1; g = g + 1) begin : g_sync
      edge_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .async_i (s_in[g]),
        .level_o (s_lvl[g]),
        .rise_o  (s_rise[g]),
        .fall_o  (s_fall[g])
      );
    end
  endgenerate
  // last bus bit, then ready clear and read enable also synchronised
  edge_sync u_sync_last (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .async_i (s_in[NS-1]),
    .level_o (s_lvl[NS-1]),
    .rise_o  (s_rise[NS-1]),
    .fall_o  (s_fall[NS-1])
  );
  wire rdc_lvl;
  wire oe_lvl;
  edge_sync u_sync_rdc (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .async_i (rx_ready_clear_i),
    .level_o (rdc_lvl),
    .rise_o  (),
    .fall_o  ()
  );
  edge_sync u_sync_oe (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .async_i (rx_out_enable_i),
    .level_o (oe_lvl),
    .rise_o  (),
    .fall_o  ()
  );
  wire [7:0] bus     = s_lvl[19:12];
  wire       txs_ld  = s_lvl[11];
  wire       txd_ld  = s_lvl[10];
  wire       rxs_ld  = s_lvl[9];
  wire       cstb    = s_lvl[8];
  wire       tclk_up = s_rise[3];
  wire       rclk_dn = s_fall[2];
  wire       sin     = s_lvl[1];
  wire       rclr    = s_lvl[0];
  wire       rclr_dn = s_fall[0];
  // control and character registers
  reg [1:0]   len_q;
  reg         npar_q;
  reg         even_q;
  reg [W-1:0] tx_sync_q;
  reg [W-1:0] tx_data_q;
  reg [W-1:0] rx_sync_q;
  reg         data_pend_q;
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      len_q     <= 2'h3;
      npar_q    <= 1'b1;
      even_q    <= 1'b0;
      tx_sync_q <= `SSRT_RST_BYTE;
      tx_data_q <= `SSRT_RST_BYTE;
      rx_sync_q <= `SSRT_RST_BYTE;
    end else if (ce_i) begin
      if (cstb) begin
        len_q  <= {s_lvl[7], s_lvl[6]};
        npar_q <= s_lvl[5];
        even_q <= s_lvl[4];
      end
      if (txs_ld)
        tx_sync_q <= bus;
      if (txd_ld)
        tx_data_q <= bus;
      if (rxs_ld)
        rx_sync_q <= bus;
    end
  end
  wire [CW-1:0] nbits = `SSRT_LEN_BASE + {2'h0, len_q};
  wire [CW-1:0] fbits = nbits + {3'h0, ~npar_q};
  // length mask
  reg [W-1:0] lmask;
  integer k;
  always @* begin
    lmask = 8'h00;
    for (k = 0; k < W; k = k + 1)
      if (k < nbits)
        lmask[k] = 1'b1;
  end
  // transmitter
  reg [W:0]    tx_sh_q;
  reg [CW-1:0] tx_cnt_q;
  reg          tx_out_q;
  reg          sync_sent_q;
  reg          tx_par_q;
  wire [W-1:0] tx_next = data_pend_q ? tx_data_q : tx_sync_q;
  wire         tx_par  = ^(tx_next & lmask) ^ ~even_q;
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_q     <= 9'h000;
      tx_cnt_q    <= 4'h0;
      tx_out_q    <= 1'b1;
      sync_sent_q <= 1'b0;
      data_pend_q <= 1'b0;
    end else if (ce_i) begin
      if (tclk_up) begin
        if (tx_cnt_q == 4'h0) begin
          tx_out_q    <= tx_next[0];
          tx_sh_q     <= {1'b0, tx_par, tx_next[W-1:1]};
          tx_cnt_q    <= fbits - 4'h1;
          sync_sent_q <= ~data_pend_q;
          data_pend_q <= txd_ld;
        end else begin
          // parity bit follows the last data bit
          if (tx_cnt_q == fbits - nbits && !npar_q)
            tx_out_q <= tx_par_q;
          else
            tx_out_q <= tx_sh_q[0];
          tx_sh_q  <= {1'b0, tx_sh_q[W:1]};
          tx_cnt_q <= tx_cnt_q - 4'h1;
          if (txd_ld)
            data_pend_q <= 1'b1;
        end
      end else if (txd_ld) begin
        data_pend_q <= 1'b1;
      end
    end
  end
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      tx_par_q <= 1'b0;
    else if (ce_i && tclk_up && tx_cnt_q == 4'h0)
      tx_par_q <= tx_par;
  end
  assign serial_out_o     = tx_out_q;
  assign tx_buffer_free_o = ~data_pend_q;
  assign tx_sync_sent_o   = sync_sent_q;
  // receiver
  reg [W:0]    rx_sh_q;
  reg [CW-1:0] rx_cnt_q;
  reg          rx_char_q;
  reg [W-1:0]  rx_buf_q;
  reg          ready_q;
  reg          ovr_q;
  reg          pfault_q;
  reg          match_q;
  // window: last fbits bits, first bit at lsb
  reg [W:0] rx_new;
  always @* begin
    rx_new = {sin, rx_sh_q[W:1]};
    rx_new = rx_new >> (4'h9 - fbits);
  end
  wire [W-1:0] rx_data = rx_new[W-1:0] & lmask;
  wire         rx_pbit = rx_new[nbits[3:0]];
  wire         rx_sync_hit = rx_data == (rx_sync_q & lmask);
  wire         rx_bad  = ~npar_q & (rx_pbit ^ ^rx_data ^ ~even_q);
  wire         rx_last = rx_char_q ? (rx_cnt_q == fbits - 4'h1) : rx_sync_hit;
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_q   <= 9'h000;
      rx_cnt_q  <= 4'h0;
      rx_char_q <= 1'b0;
      rx_buf_q  <= `SSRT_RST_BYTE;
      ready_q   <= 1'b0;
      ovr_q     <= 1'b0;
      pfault_q  <= 1'b0;
      match_q   <= 1'b0;
    end else if (ce_i) begin
      if (rclr) begin
        ready_q   <= 1'b0;
        ovr_q     <= 1'b0;
        pfault_q  <= 1'b0;
        match_q   <= 1'b0;
        rx_char_q <= 1'b0;
        rx_cnt_q  <= 4'h0;
      end else if (rclk_dn) begin
        rx_sh_q <= {sin, rx_sh_q[W:1]};
        if (rx_last) begin
          rx_buf_q  <= rx_data;
          rx_char_q <= 1'b1;
          rx_cnt_q  <= 4'h0;
          ready_q   <= 1'b1;
          ovr_q     <= ready_q & ~rdc_lvl;
          pfault_q  <= rx_bad;
          match_q   <= rx_sync_hit;
        end else begin
          rx_cnt_q <= rx_char_q ? rx_cnt_q + 4'h1 : 4'h0;
          if (rdc_lvl)
            ready_q <= 1'b0;
        end
      end else if (rdc_lvl) begin
        ready_q <= 1'b0;
      end
      if (rclr_dn)
        rx_char_q <= 1'b0;
    end
  end
  assign rx_char_out_o     = rx_buf_q;
  assign rx_char_out_oe_o  = {W{oe_lvl}};
  assign rx_char_ready_o   = ready_q;
  assign rx_overrun_flag_o = ovr_q;
  assign rx_parity_fault_o = pfault_q & ~npar_q;
  assign rx_sync_match_o   = match_q;
endmodule // sync_serial_rx_tx
`default_nettype wire

// [include/sync_serial_consts.vh]
// constants for the synchronous serial receiver and transmitter
`ifndef SYNC_SERIAL_CONSTS_VH
`define SYNC_SERIAL_CONSTS_VH
`define SSRT_CHAR_W      8
`define SSRT_CNT_W       4
`define SSRT_LEN_BASE    4'h5
`define SSRT_IDLE_CHAR   8'h00
`define SSRT_RST_BYTE    8'h00
`endif

// [rtl/edge_sync.v]
// two-flop synchroniser with rise and fall detection
`default_nettype none
module edge_sync (
  input  wire mclk_i,
  input  wire rst_n_i,
  input  wire ce_i,
  input  wire async_i,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_q;
  reg sync_q;
  reg prev_q;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level_o = sync_q;
  assign rise_o  = ce_i & sync_q & ~prev_q;
  assign fall_o  = ce_i & ~sync_q & prev_q;
endmodule // edge_sync
`default_nettype wire

// [dv/sync_serial_checker.sv]
// assertion checker for the serial receiver and transmitter
`default_nettype none
module sync_serial_checker (
  input wire logic       mclk_i,
  input wire logic       rstn_i,
  input wire logic       control_load_strobe_i,
  input wire logic       parity_disable_i,
  input wire logic       tx_data_load_strobe_i,
  input wire logic       tx_bit_clock_i,
  input wire logic       receiver_clear_i,
  input wire logic       rx_ready_clear_i,
  input wire logic       rx_out_enable_i,
  input wire logic [7:0] rx_char_out_oe_o,
  input wire logic       rx_char_ready_o,
  input wire logic       rx_overrun_flag_o,
  input wire logic       rx_parity_fault_o,
  input wire logic       rx_sync_match_o,
  input wire logic       serial_out_o,
  input wire logic       tx_buffer_free_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  a_oe_follows_enable: assert property ($stable(rx_out_enable_i)[*4]
    |-> rx_char_out_oe_o == {8{rx_out_enable_i}}) else $error("output enable wrong");
  a_fault_masked: assert property ((control_load_strobe_i && parity_disable_i)[*6]
    |-> !rx_parity_fault_o) else $error("parity fault while disabled");
  a_ready_cleared: assert property (rx_ready_clear_i[*5] |-> !rx_char_ready_o)
    else $error("ready not cleared");
  a_overrun_cause: assert property ($rose(rx_overrun_flag_o) |-> $past(rx_char_ready_o))
    else $error("overrun without pending ready");
  a_tx_shift_edge: assert property ($changed(serial_out_o)
    |-> $past(tx_bit_clock_i, 3) && !$past(tx_bit_clock_i, 5)) else $error("tx bit off edge");
  a_free_after_load: assert property ($fell(tx_buffer_free_o)
    |-> $past(tx_data_load_strobe_i, 2) || $past(tx_data_load_strobe_i, 4))
    else $error("buffer taken without strobe");
  a_clear_flags: assert property (receiver_clear_i[*5]
    |-> !rx_char_ready_o && !rx_sync_match_o && !rx_overrun_flag_o && !rx_parity_fault_o)
    else $error("flags not cleared");
  a_ready_stands: assert property ($fell(rx_char_ready_o)
    |-> $past(rx_ready_clear_i, 3) || $past(rx_ready_clear_i, 4) || $past(receiver_clear_i, 3))
    else $error("ready dropped alone");
endmodule // sync_serial_checker
bind sync_serial_rx_tx sync_serial_checker u_chk (.mclk_i, .rstn_i, .control_load_strobe_i,
  .parity_disable_i, .tx_data_load_strobe_i, .tx_bit_clock_i, .receiver_clear_i,
  .rx_ready_clear_i, .rx_out_enable_i, .rx_char_out_oe_o, .rx_char_ready_o, .rx_overrun_flag_o,
  .rx_parity_fault_o, .rx_sync_match_o, .serial_out_o, .tx_buffer_free_o);
`default_nettype wire

// [dv/serial_peer.sv]
// serial line peer: sends receive frames, clocks and captures transmit frames
`default_nettype none
module serial_peer (
  input  wire logic mclk_i,
  input  wire logic serial_out_i,
  output var logic  rx_bit_clock_o,
  output var logic  serial_in_o,
  output var logic  tx_bit_clock_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_bit_clock_o = 1'b0;
    serial_in_o = 1'b1;
    tx_bit_clock_o = 1'b0;
  end
  // lsb first, bit changes on clock rise and holds over the fall; clock idles low
  task automatic send_bits(input logic [8:0] val, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_o <= val[i];
      rx_bit_clock_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      rx_bit_clock_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
    repeat (2) @(posedge mclk_i);
    serial_in_o <= ~val[n-1];
  endtask
  task automatic recv_bits(output logic [7:0] val, input int n);
    val = 8'h00;
    for (int i = 0; i < n; i++) begin
      tx_bit_clock_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      tx_bit_clock_o <= 1'b0;
      @(posedge mclk_i);
      val[i] = serial_out_i;
      repeat (3) @(posedge mclk_i);
    end
  endtask
endmodule // serial_peer
`default_nettype wire

// [dv/tb_sync_serial_rx_tx.sv]
// self-checking bench for the serial receiver and transmitter
`default_nettype none
module tb_sync_serial_rx_tx;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic [7:0] bus = 8'h00;
  logic [4:0] stb = 5'h00;
  logic       len_hi = 1'b0, len_lo = 1'b0, pdis = 1'b0, psen = 1'b0, rclr = 1'b1, rd_en = 1'b0;
  wire        rxck, sin, txck, sout, ready, ovr, pfault, smatch, bfree, sent;
  wire  [7:0] dout, doe;
  int         errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  always #25 mclk_i = ~mclk_i;
  sync_serial_rx_tx u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .parallel_in_bus_i(bus), .tx_sync_load_strobe_i(stb[0]), .tx_data_load_strobe_i(stb[1]),
    .rx_sync_load_strobe_i(stb[2]), .control_load_strobe_i(stb[3]), .length_sel_hi_i(len_hi),
    .length_sel_lo_i(len_lo), .parity_disable_i(pdis), .parity_sense_i(psen),
    .tx_bit_clock_i(txck), .rx_bit_clock_i(rxck), .serial_in_i(sin), .receiver_clear_i(rclr),
    .rx_ready_clear_i(stb[4]), .rx_out_enable_i(rd_en), .rx_char_out_o(dout),
    .rx_char_out_oe_o(doe), .rx_char_ready_o(ready), .rx_overrun_flag_o(ovr),
    .rx_parity_fault_o(pfault), .rx_sync_match_o(smatch), .serial_out_o(sout),
    .tx_buffer_free_o(bfree), .tx_sync_sent_o(sent));
  serial_peer u_peer (.mclk_i(mclk_i), .serial_out_i(sout), .rx_bit_clock_o(rxck),
    .serial_in_o(sin), .tx_bit_clock_o(txck));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bus held for the whole strobe; 0 tx sync, 1 tx data, 2 rx sync, 3 control, 4 ready clear
  task automatic strobe(input int b, input logic [7:0] v);
    bus <= v;
    stb[b] <= 1'b1;
    repeat (8) @(posedge mclk_i);
    stb[b] <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic t_sync_search;
    strobe(2, 8'h16);
    rclr <= 1'b0;
    repeat (6) @(posedge mclk_i);
    u_peer.send_bits(9'h016, 8);
    check(ready, 8'h01);
    check(smatch, 8'h01);
    u_peer.send_bits(9'h0A5, 8);
    check(ovr, 8'h01);
    check(smatch, 8'h00);
    check(doe, 8'h00);
    rd_en <= 1'b1;
    repeat (4) @(posedge mclk_i);
    check(doe, 8'hFF);
    check(dout, 8'hA5);
    strobe(4, 8'h00);
    check(ready, 8'h00);
  endtask
  task automatic t_parity;
    logic [7:0] d;
    logic       p;
    for (int k = 0; k < 4; k++) begin
      d = 8'hB7 & 8'((1 << (5 + k)) - 1);
      p = ^d ^ ~k[0];
      {len_hi, len_lo} <= k[1:0];
      psen <= k[0];
      strobe(3, 8'h00);
      u_peer.send_bits({1'b0, d} | (9'(p) << (5 + k)), 6 + k);
      check(dout, d);
      check(pfault, 8'h00);
      u_peer.send_bits({1'b0, d} | (9'(~p) << (5 + k)), 6 + k);
      check(pfault, 8'h01);
    end
    pdis <= 1'b1;
    strobe(3, 8'h00);
    u_peer.send_bits(9'h0C3, 8);
    check(pfault, 8'h00);
    check(dout, 8'hC3);
  endtask
  task automatic t_tx;
    logic [7:0] got;
    strobe(0, 8'h3C);
    u_peer.recv_bits(got, 8);
    check(got, 8'h3C);
    check(sent, 8'h01);
    strobe(1, 8'h5A);
    check(bfree, 8'h00);
    u_peer.recv_bits(got, 8);
    check(got, 8'h5A);
    check(sent, 8'h00);
    check(bfree, 8'h01);
    u_peer.recv_bits(got, 8);
    check(got, 8'h3C);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t_sync_search();
    t_parity();
    t_tx();
    complete_run();
  end
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      complete_run();
    end
  end
endmodule // tb_sync_serial_rx_tx
`default_nettype wire
